// [hdl/tdc_desc_decode.v]
// transmit descriptor control word decoder with axi4-lite registers
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`include "tdc_map.vh"
`default_nettype none

module tdc_desc_decode #(
  parameter LW = 16
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          srst,
  // descriptor control word from the fetch engine
  input  wire          descValid,
  input  wire [31:0]   descWord,
  output reg           descReady,
  // completion of the frame in flight from the transmitter
  input  wire          txDone,
  // decoded descriptor, valid for one cycle
  output reg           decValid,
  output reg           buf1Use,
  output reg  [10:0]   buf1Len,
  output reg           buf2Use,
  output reg  [10:0]   buf2Len,
  output reg  [1:0]    nextMode,
  output reg           frameStart,
  output reg           frameEnd,
  output reg           setupFrame,
  // frame and filter results
  output wire          frameDone,
  output wire [6:0]    padBytes,
  output wire          crcAppend,
  output reg  [1:0]    filterType,
  output reg           filterLoad,
  output wire          txIntStatus,
  // axi4-lite slave
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready
);

  //--------------------------------------------------------------------
  // field extraction
  //--------------------------------------------------------------------
  wire        take;
  wire        completion_irq_req;
  wire        final_segment_flag;
  wire        opening_segment_flag;
  wire        filter_type_hi;
  wire        filter_type_lo;
  wire        setupFlag;
  wire        no_crc_append;
  wire        ring_wrap_flag;
  wire        chain_next_ptr;
  wire        no_pad_flag;
  wire [10:0] buf1_len;
  wire [10:0] buf2_len;
  wire [10:0] buf2Eff;
  wire [11:0] descLen;
  wire        honourIrq;
  wire        dataTake;

  assign take                 = descValid & descReady;
  assign completion_irq_req   = descWord[`TDC_IRQ_REQ_BIT];
  assign final_segment_flag   = descWord[`TDC_FINAL_SEG_BIT];
  assign opening_segment_flag = descWord[`TDC_OPEN_SEG_BIT];
  assign filter_type_hi       = descWord[`TDC_FILT_HI_BIT];
  assign filter_type_lo       = descWord[`TDC_FILT_LO_BIT];
  assign setupFlag            = descWord[`TDC_SETUP_BIT];
  assign no_crc_append        = descWord[`TDC_NO_CRC_BIT];
  assign ring_wrap_flag       = descWord[`TDC_RING_WRAP_BIT];
  assign chain_next_ptr       = descWord[`TDC_CHAIN_BIT];
  assign no_pad_flag          = descWord[`TDC_NO_PAD_BIT];
  assign buf1_len             = descWord[`TDC_BUF1_HI:`TDC_BUF1_LO];
  assign buf2_len             = descWord[`TDC_BUF2_HI:`TDC_BUF2_LO];

  // a chained second word is a pointer, never a buffer
  assign buf2Eff   = chain_next_ptr ? 11'h000 : buf2_len;
  assign descLen   = {1'b0, buf1_len} + {1'b0, buf2Eff};
  assign honourIrq = completion_irq_req & (final_segment_flag | setupFlag);
  // setup frames never enter the transmit frame accounting
  assign dataTake  = take & ~setupFlag;

  //--------------------------------------------------------------------
  // software visible state
  //--------------------------------------------------------------------
  reg  [31:0]   ctrlReg;
  reg  [31:0]   lastWord;
  reg           filterSeen;
  reg           irqPending;
  wire          decodeEn;
  wire          inFrame;
  wire [LW-1:0] frameLen;
  wire          statusClr;

  assign decodeEn = ctrlReg[`TDC_CTRL_EN_BIT];

  //--------------------------------------------------------------------
  // descriptor acceptance and decode
  //--------------------------------------------------------------------
  // one bubble after each word keeps ready a plain flop
  always @(posedge ref_clk) begin
    if (srst) begin
      descReady  <= 1'b0;
      decValid   <= 1'b0;
      buf1Use    <= 1'b0;
      buf1Len    <= 11'h000;
      buf2Use    <= 1'b0;
      buf2Len    <= 11'h000;
      nextMode   <= `TDC_NEXT_SEQ;
      frameStart <= 1'b0;
      frameEnd   <= 1'b0;
      setupFrame <= 1'b0;
      filterType <= `TDC_FILT_PERFECT;
      filterLoad <= 1'b0;
      filterSeen <= 1'b0;
      lastWord   <= 32'h00000000;
    end else begin
      descReady  <= decodeEn & ~take;
      decValid   <= take;
      filterLoad <= 1'b0;
      if (take) begin
        lastWord   <= descWord;
        buf1Use    <= (buf1_len != 11'h000);
        buf1Len    <= buf1_len;
        buf2Use    <= (buf2Eff != 11'h000);
        buf2Len    <= buf2Eff;
        frameStart <= opening_segment_flag & ~setupFlag;
        frameEnd   <= final_segment_flag & ~setupFlag;
        setupFrame <= setupFlag;
        // ring wrap is checked first so it wins over chaining
        if (ring_wrap_flag) begin
          nextMode <= `TDC_NEXT_RING;
        end else if (chain_next_ptr) begin
          nextMode <= `TDC_NEXT_CHAIN;
        end else begin
          nextMode <= `TDC_NEXT_SEQ;
        end
        if (setupFlag) begin
          filterType <= {filter_type_hi, filter_type_lo};
          filterLoad <= 1'b1;
          filterSeen <= 1'b1;
        end
      end
    end
  end

  //--------------------------------------------------------------------
  // completion interrupt
  //--------------------------------------------------------------------
  // pending request waits for the transmitter to finish the frame
  always @(posedge ref_clk) begin
    if (srst) begin
      irqPending <= 1'b0;
    end else if (take & honourIrq) begin
      irqPending <= 1'b1;
    end else if (txDone) begin
      irqPending <= 1'b0;
    end
  end

  tdc_sticky_flag u_txint (
    .ref_clk (ref_clk),
    .srst    (srst),
    .setEv   (txDone & irqPending),
    .clrEv   (statusClr),
    .flag    (txIntStatus)
  );

  //--------------------------------------------------------------------
  // frame tracking
  //--------------------------------------------------------------------
  tdc_frame_track #(
    .LW (LW)
  ) u_frame (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .take      (dataTake),
    .openSeg   (opening_segment_flag),
    .finalSeg  (final_segment_flag),
    .noCrc     (no_crc_append),
    .noPad     (no_pad_flag),
    .descLen   (descLen),
    .inFrame   (inFrame),
    .frameLen  (frameLen),
    .frameDone (frameDone),
    .padBytes  (padBytes),
    .crcOn     (crcAppend)
  );

  //--------------------------------------------------------------------
  // axi4-lite write channel
  //--------------------------------------------------------------------
  reg  [7:0] awAddr;
  reg        awHeld;
  reg  [31:0] wData;
  reg  [3:0] wStrb;
  reg        wHeld;
  wire       doWrite;
  wire       wrMapped;
  wire [31:0] strbMask;

  assign doWrite  = awHeld & wHeld & ~s_axi_bvalid;
  assign wrMapped = (awAddr == `TDC_REG_CTRL) | (awAddr == `TDC_REG_STATUS);
  assign strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  // status is write-one-to-clear on bit 0
  assign statusClr = doWrite & (awAddr == `TDC_REG_STATUS) & wStrb[0]
                     & wData[`TDC_STAT_TXINT_BIT];

  // address and data are caught separately, in either order
  always @(posedge ref_clk) begin
    if (srst) begin
      awAddr        <= 8'h00;
      awHeld        <= 1'b0;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TDC_RESP_OKAY;
      ctrlReg       <= `TDC_CTRL_RESET;
    end else begin
      s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `TDC_RESP_OKAY : `TDC_RESP_SLVERR;
        if (awAddr == `TDC_REG_CTRL) begin
          ctrlReg <= (ctrlReg & ~strbMask) | (wData & strbMask & 32'h00000001);
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // axi4-lite read channel
  //--------------------------------------------------------------------
  reg [31:0] rdMux;
  reg        rdHit;

  // read data selection
  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (s_axi_araddr)
      `TDC_REG_CTRL:     rdMux = ctrlReg;
      `TDC_REG_STATUS:   rdMux = {29'h00000000, inFrame, irqPending, txIntStatus};
      `TDC_REG_FILTER:   rdMux = {29'h00000000, filterSeen, filterType};
      `TDC_REG_LASTWORD: rdMux = lastWord;
      `TDC_REG_FRAMELEN: rdMux = {{(32-LW){1'b0}}, frameLen};
      default:           rdHit = 1'b0;
    endcase
  end

  // one read in flight; arready returns after the data is taken
  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TDC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `TDC_RESP_OKAY : `TDC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tdc_desc_decode

`default_nettype wire

// [hdl/tdc_map.vh]
// constants for the transmit descriptor control word decoder
`ifndef TDC_MAP_VH
`define TDC_MAP_VH

// control word field positions
`define TDC_IRQ_REQ_BIT    31
`define TDC_FINAL_SEG_BIT  30
`define TDC_OPEN_SEG_BIT   29
`define TDC_FILT_HI_BIT    28
`define TDC_SETUP_BIT      27
`define TDC_NO_CRC_BIT     26
`define TDC_RING_WRAP_BIT  25
`define TDC_CHAIN_BIT      24
`define TDC_NO_PAD_BIT     23
`define TDC_FILT_LO_BIT    22
`define TDC_BUF2_HI        21
`define TDC_BUF2_LO        11
`define TDC_BUF1_HI        10
`define TDC_BUF1_LO        0

// shortest frame before padding, in bytes
`define TDC_MIN_FRAME      7'h40

// next descriptor address modes
`define TDC_NEXT_SEQ       2'h0
`define TDC_NEXT_CHAIN     2'h1
`define TDC_NEXT_RING      2'h2

// filter type codes
`define TDC_FILT_PERFECT   2'h0
`define TDC_FILT_HASH_ONE  2'h1
`define TDC_FILT_INVERSE   2'h2
`define TDC_FILT_HASH_ONLY 2'h3

// register byte offsets
`define TDC_REG_CTRL       8'h00
`define TDC_REG_STATUS     8'h04
`define TDC_REG_FILTER     8'h08
`define TDC_REG_LASTWORD   8'h0C
`define TDC_REG_FRAMELEN   8'h10

// register bits and reset values
`define TDC_CTRL_EN_BIT    0
`define TDC_CTRL_RESET     32'h00000001
`define TDC_STAT_TXINT_BIT 0

// bus responses
`define TDC_RESP_OKAY      2'h0
`define TDC_RESP_SLVERR    2'h2

`endif

// [hdl/tdc_sticky_flag.v]
// sticky flag where a set in the clearing cycle wins
`default_nettype none

module tdc_sticky_flag (
  // clock and reset
  input  wire ref_clk,
  input  wire srst,
  // events
  input  wire setEv,
  input  wire clrEv,
  // state
  output reg  flag
);

  // set beats clear so an event never slips through
  always @(posedge ref_clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (setEv) begin
      flag <= 1'b1;
    end else if (clrEv) begin
      flag <= 1'b0;
    end
  end

endmodule // tdc_sticky_flag

`default_nettype wire

// [hdl/tdc_frame_track.v]
// per-frame length, padding and crc tracking across descriptors
`include "tdc_map.vh"
`default_nettype none

module tdc_frame_track #(
  parameter LW = 16
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          srst,
  // accepted data descriptor
  input  wire          take,
  input  wire          openSeg,
  input  wire          finalSeg,
  input  wire          noCrc,
  input  wire          noPad,
  input  wire [11:0]   descLen,
  // frame results
  output reg           inFrame,
  output reg  [LW-1:0] frameLen,
  output reg           frameDone,
  output reg  [6:0]    padBytes,
  output reg           crcOn
);

  reg           noCrcHeld;
  wire [LW-1:0] curLen;
  wire          crcOff;
  wire          padOn;

  // a frame restarts its byte count on every opening segment
  assign curLen = (openSeg ? {LW{1'b0}} : frameLen) + {{(LW-12){1'b0}}, descLen};
  assign crcOff = openSeg ? noCrc : noCrcHeld;
  assign padOn  = (curLen < {{(LW-7){1'b0}}, `TDC_MIN_FRAME}) & ~noPad;

  always @(posedge ref_clk) begin
    if (srst) begin
      inFrame   <= 1'b0;
      frameLen  <= {LW{1'b0}};
      frameDone <= 1'b0;
      padBytes  <= 7'h00;
      crcOn     <= 1'b1;
      noCrcHeld <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      if (take) begin
        frameLen <= curLen;
        if (openSeg) begin
          noCrcHeld <= noCrc;
          inFrame   <= 1'b1;
        end
        if (finalSeg) begin
          inFrame   <= 1'b0;
          frameDone <= 1'b1;
          padBytes  <= padOn ? (`TDC_MIN_FRAME - curLen[6:0]) : 7'h00;
          crcOn     <= ~crcOff | padOn;
        end
      end
    end
  end

endmodule // tdc_frame_track

`default_nettype wire

// [dv/tdc_desc_properties.sv]
// port assertions for the descriptor control word decoder
`default_nettype none
module tdc_desc_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // descriptor side
  input wire logic        descValid,
  input wire logic [31:0] descWord,
  input wire logic        descReady,
  input wire logic        txDone,
  // decoded outputs
  input wire logic        decValid,
  input wire logic [10:0] buf1Len,
  input wire logic        buf1Use,
  input wire logic [10:0] buf2Len,
  input wire logic [1:0]  nextMode,
  input wire logic        frameStart,
  input wire logic        frameEnd,
  input wire logic        setupFrame,
  input wire logic        frameDone,
  input wire logic [6:0]  padBytes,
  input wire logic        crcAppend,
  input wire logic [1:0]  filterType,
  input wire logic        filterLoad,
  input wire logic        txIntStatus
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // one domain, so clock and reset once
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // the steps of a descriptor take
  sequence s_take;
    descValid && descReady;
  endsequence
  sequence s_setup;
    s_take ##0 descWord[27];
  endsequence
  sequence s_final;
    s_take ##0 (descWord[30] && !descWord[27]);
  endsequence
  // decode strobe lasts one cycle, since ready drops after each take
  chk_dec_pulse: assert property (
    s_take |=> decValid ##1 !decValid)
    else $error("decode strobe not a single pulse");
  chk_buf1_len: assert property (
    s_take |=> buf1Len == $past(descWord[10:0]) && buf1Use == (buf1Len != 11'h000))
    else $error("buffer one length wrong");
  chk_buf2_len: assert property (
    s_take |=> buf2Len == ($past(descWord[24]) ? 11'h000 : $past(descWord[21:11])))
    else $error("buffer two length wrong");
  chk_next_mode: assert property (
    s_take |=> nextMode == ($past(descWord[25]) ? 2'h2 : {1'b0, $past(descWord[24])}))
    else $error("next descriptor mode wrong");
  chk_seg_flags: assert property (
    s_take |=> setupFrame == $past(descWord[27])
      && frameStart == ($past(descWord[29]) && !setupFrame)
      && frameEnd == ($past(descWord[30]) && !setupFrame))
    else $error("segment flags wrong");
  chk_frame_done: assert property (
    s_final |=> frameDone) else $error("frame end not flagged");
  chk_filter_load: assert property (
    s_setup |=> filterLoad && filterType == {$past(descWord[28]), $past(descWord[22])})
    else $error("filter type not loaded");
  chk_filter_hold: assert property (
    !filterLoad |-> $stable(filterType)) else $error("filter type changed");
  chk_pad_crc: assert property (
    frameDone && padBytes != 7'h00 |-> crcAppend) else $error("padded frame lacks crc");
  chk_irq_cause: assert property (
    $rose(txIntStatus) |-> $past(txDone)) else $error("interrupt without completion");
endmodule // tdc_desc_props

bind tdc_desc_decode tdc_desc_props u_props (.ref_clk, .srst, .descValid, .descWord,
  .descReady, .txDone, .decValid, .buf1Len, .buf1Use, .buf2Len, .nextMode, .frameStart, .frameEnd,
  .setupFrame, .frameDone, .padBytes, .crcAppend, .filterType, .filterLoad, .txIntStatus);
`default_nettype wire

// [dv/tdc_host_mem.sv]
// host memory model serving descriptor control words
`default_nettype none
module tdc_host_mem (
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         srst,
  // bench control
  input wire logic         go,
  input wire logic [2:0]   cnt,
  input wire logic         slow,
  output logic             busy,
  // descriptor port
  input wire logic         descReady,
  output logic             descValid,
  output logic [31:0]      descWord
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [0:7];
  logic [2:0]  idx;
  logic        gap;
  // words leave in list order, each held until taken
  always @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
      descValid <= 1'b0;
      descWord <= 32'hFFFFFFFF;
      idx <= 3'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      idx <= 3'h0;
      gap <= slow;
    end else if (busy && descValid && descReady) begin
      descValid <= 1'b0;
      descWord <= ~descWord; // released: show no stale word
      idx <= idx + 3'h1;
      gap <= slow;
      busy <= (idx != cnt);
    end else if (busy && !descValid) begin
      gap <= 1'b0; // slow mode idles a cycle first
      descValid <= !gap;
      descWord <= gap ? ~descWord : mem[idx];
    end
  end
endmodule // tdc_host_mem
`default_nettype wire

// [dv/tdc_desc_decode_tb.sv]
// testbench for the descriptor control word decoder
`include "tdc_map.vh"
`default_nettype none
module tdc_desc_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals, design and host model
  // ----------------------------------------
  logic ref_clk, srst, txDone, go, slow, busy, descValid, descReady, decValid;
  logic buf1Use, buf2Use, frameStart, frameEnd, setupFrame, frameDone, crcAppend;
  logic filterLoad, txIntStatus, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [2:0]  cnt;
  logic [31:0] descWord, s_axi_wdata, s_axi_rdata;
  logic [10:0] buf1Len, buf2Len;
  logic [1:0]  nextMode, filterType, s_axi_bresp, s_axi_rresp;
  logic [6:0]  padBytes;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  int err_total = 0;
  int tests_run = 0;
  tdc_desc_decode dut (.ref_clk, .srst, .descValid, .descWord, .descReady, .txDone,
    .decValid, .buf1Use, .buf1Len, .buf2Use, .buf2Len, .nextMode, .frameStart, .frameEnd,
    .setupFrame, .frameDone, .padBytes, .crcAppend, .filterType, .filterLoad, .txIntStatus,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tdc_host_mem host (.ref_clk, .srst, .go, .cnt, .slow, .busy, .descReady, .descValid,
    .descWord);
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a spent bound ends the run at once
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      summarize();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    guard(i < 50);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(i < 50);
  endtask
  // hand the host one or two words and wait until all are taken
  task automatic send(input logic [31:0] w0, w1, input logic [2:0] n, input logic s);
    int i;
    host.mem[0] = w0;
    host.mem[1] = w1;
    @(posedge ref_clk);
    go <= 1'b1;
    cnt <= n;
    slow <= s;
    @(posedge ref_clk);
    go <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (!busy) break;
    end
    guard(i < 50);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic pulse;
    @(posedge ref_clk);
    txDone <= 1'b1;
    @(posedge ref_clk);
    txDone <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(`TDC_REG_CTRL, d, r);
    chk(d, `TDC_CTRL_RESET);
    axr(`TDC_REG_STATUS, d, r);
    chk(d, 32'h00000000);
    axr(8'h40, d, r);
    chk({d[1:0], r}, {2'h0, `TDC_RESP_SLVERR});
    axw(`TDC_REG_FILTER, 32'h00000003, r);
    chk(r, `TDC_RESP_SLVERR);
    axw(`TDC_REG_CTRL, 32'h00000000, r);
    repeat (3) @(posedge ref_clk);
    chk(descReady, 1'b0);
    axw(`TDC_REG_CTRL, 32'h00000001, r);
  endtask
  // 10+20+33 = 63 bytes: one pad byte, crc forced back on
  task automatic t_short;
    logic [1:0]  r;
    logic [31:0] d;
    send(32'h2400A00A, 32'hC1002821, 3'h1, 1'b0);
    axr(`TDC_REG_FRAMELEN, d, r);
    chk(d, 32'h0000003F);
    chk(padBytes, 7'h01);
    chk(crcAppend, 1'b1);
    chk({buf2Use, buf2Len}, 12'h000);
    chk(nextMode, `TDC_NEXT_CHAIN);
    chk({frameStart, frameEnd}, 2'h1);
    pulse();
    chk(txIntStatus, 1'b1);
    axw(`TDC_REG_STATUS, 32'h00000001, r);
    chk(txIntStatus, 1'b0);
  endtask
  // unpadded 40 bytes without crc, ring beats chain, slow host
  task automatic t_nopad;
    send(32'h67800028, 32'h00000000, 3'h0, 1'b1);
    chk(padBytes, 7'h00);
    chk(crcAppend, 1'b0);
    chk(nextMode, `TDC_NEXT_RING);
    chk({buf1Use, buf2Use}, 2'h2);
  endtask
  // 69 bytes; crc disable and completion only on the wrong words
  task automatic t_ignored;
    send(32'hA0000005, 32'h44000040, 3'h1, 1'b0);
    chk(padBytes, 7'h00);
    chk(crcAppend, 1'b1);
    pulse();
    chk(txIntStatus, 1'b0);
  endtask
  task automatic t_filter;
    logic [1:0] r;
    int k;
    for (k = 0; k < 4; k++) begin
      send(32'h880000C0 | (32'(k[1]) << 28) | (32'(k[0]) << 22), 32'h0, 3'h0, 1'b0);
      chk(filterType, k[1:0]);
      chk({setupFrame, frameStart}, 2'h2);
    end
    pulse();
    chk(txIntStatus, 1'b1);
    // data word with filter bits 00: a wrongly applied type would show 0
    send(32'h60000010, 32'h0, 3'h0, 1'b0);
    chk(filterType, `TDC_FILT_HASH_ONLY);
    axw(`TDC_REG_STATUS, 32'h00000001, r);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    txDone = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    cnt = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_short();
    t_nopad();
    t_ignored();
    t_filter();
    summarize();
  end
endmodule // tdc_desc_decode_tb
`default_nettype wire
